// ===== verilog/asr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module asr_regs #(
  parameter logic [7:0] CHIP_IDENTIFIER    = 8'h5A,  // arbitrary value
  parameter logic [2:0] SPEED_CODE = 3'h0
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire asr_pkg::asr_req_t req,
  input  wire logic              pdwn_pin,
  output var  logic [7:0]        rdata_q,
  output var  logic              rvalid_q,
  output var  logic              lsb_first_q,
  output var  asr_pkg::asr_ctl_t ctl
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       lsb_q;
  logic       srst_q;
  logic [7:0] idx_q;
  logic [7:0] pwr_q;
  logic [7:0] clk_q;
  logic [7:0] xfer_q;
  logic [7:0] loc_q [asr_pkg::NUM_CHAN];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       wr_ok   = req.wr && !srst_q;
  wire logic       wr_cfg  = wr_ok && (req.addr == asr_pkg::ADDR_PORT_CFG);
  wire logic       wr_idx  = wr_ok && (req.addr == asr_pkg::ADDR_CHAN_IDX);
  wire logic       wr_pwr  = wr_ok && (req.addr == asr_pkg::ADDR_PWR_MODE);
  wire logic       wr_clk  = wr_ok && (req.addr == asr_pkg::ADDR_CLK_STAB);
  wire logic       wr_xfer = wr_ok && (req.addr == asr_pkg::ADDR_TRANSFER);
  wire logic       wr_loc  = wr_ok && (req.addr == asr_pkg::ADDR_LOCAL_CFG);
  // either nibble carries the control, whichever order the byte came in
  wire logic       w_lsb   = req.wdata[asr_pkg::CFG_LSB_HI]
                           | req.wdata[asr_pkg::CFG_LSB_LO];
  wire logic       w_srst  = req.wdata[asr_pkg::CFG_SRST_HI]
                           | req.wdata[asr_pkg::CFG_SRST_LO];
  wire logic [7:0] cfg_val = {1'b0, lsb_q, srst_q, 1'b1,
                              1'b1, srst_q, lsb_q, 1'b0};

  // local read picks channel A first, so all-set returns A
  wire logic [7:0] loc_rd  = idx_q[0] ? loc_q[0] :
                             idx_q[1] ? loc_q[1] :
                             idx_q[2] ? loc_q[2] :
                             idx_q[3] ? loc_q[3] : 8'h00;

  logic [7:0] rdata_d;
  always_comb
  begin
    case (req.addr)
      asr_pkg::ADDR_PORT_CFG:  rdata_d = cfg_val;
      asr_pkg::ADDR_CHIP_IDENTIFIER:   rdata_d = CHIP_IDENTIFIER;
      asr_pkg::ADDR_SPEED:     rdata_d = {1'b0, SPEED_CODE, 4'h0};
      asr_pkg::ADDR_CHAN_IDX:  rdata_d = idx_q;
      asr_pkg::ADDR_PWR_MODE:  rdata_d = pwr_q;
      asr_pkg::ADDR_CLK_STAB:  rdata_d = clk_q;
      asr_pkg::ADDR_TRANSFER:  rdata_d = xfer_q;
      asr_pkg::ADDR_LOCAL_CFG: rdata_d = loc_rd;
      default:                 rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------
  wire logic soft_clr = sys_rst || srst_q;

  always_ff @(posedge clk_sys)
  begin
    if (soft_clr)
    begin
      lsb_q  <= asr_pkg::RST_PORT_CFG[asr_pkg::CFG_LSB_HI];
      srst_q <= 1'b0;
      idx_q  <= asr_pkg::RST_CHAN_IDX;
      pwr_q  <= asr_pkg::RST_PWR_MODE;
      clk_q  <= asr_pkg::RST_CLK_STAB;
      xfer_q <= asr_pkg::RST_TRANSFER;
    end
    else
    begin
      if (wr_cfg)
      begin
        lsb_q  <= w_lsb;
        srst_q <= w_srst;
      end
      if (wr_idx)  idx_q  <= req.wdata & asr_pkg::MSK_CHAN_IDX;
      if (wr_pwr)  pwr_q  <= req.wdata & asr_pkg::MSK_PWR_MODE;
      if (wr_clk)  clk_q  <= req.wdata & asr_pkg::MSK_CLK_STAB;
      if (wr_xfer) xfer_q <= req.wdata & asr_pkg::MSK_TRANSFER;
    end
  end

  // ----------------------------------------------------------------
  // per-channel local copies
  // ----------------------------------------------------------------
  for (genvar i = 0; i < asr_pkg::NUM_CHAN; i++)
  begin : g_loc
    always_ff @(posedge clk_sys)
    begin
      if (soft_clr)
        loc_q[i] <= asr_pkg::RST_LOCAL_CFG;
      else if (wr_loc && idx_q[i])
        loc_q[i] <= req.wdata & asr_pkg::MSK_LOCAL_CFG;
    end

    a_local_copy_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wr_loc && idx_q[i] |=> loc_q[i] == $past(req.wdata))
      else $error("local copy missed a selected write");
    a_local_copy_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !srst_q && !(wr_loc && idx_q[i]) |=> $stable(loc_q[i]))
      else $error("local copy changed while unselected");
    a_srst_local_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
      srst_q |=> loc_q[i] == asr_pkg::RST_LOCAL_CFG)
      else $error("local copy kept its value through soft reset");
  end

  // ----------------------------------------------------------------
  // read port and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.rd;
      if (req.rd) rdata_q <= rdata_d;
    end
  end


  // ----------------------------------------------------------------
  // power and clock controls
  // ----------------------------------------------------------------
  wire logic [1:0] pm          = pwr_q[1:0];
  wire logic       pin_stby    = pwr_q[asr_pkg::PWR_PIN_STBY];
  wire logic       full_pd_w   = (pm == asr_pkg::PM_FULL) || (pdwn_pin && !pin_stby);
  wire logic       stby_w      = (pm == asr_pkg::PM_STBY) || (pdwn_pin && pin_stby);
  wire logic       reset_w     = (pm == asr_pkg::PM_RESET);
  wire logic       dcs_off_w   = clk_q[asr_pkg::CLK_DCS_OFF];
  wire logic       xfer_init_w = xfer_q[asr_pkg::XFER_INIT];

  assign lsb_first_q = lsb_q;
  // one driver for the whole struct, fields in declaration order
  assign ctl = {full_pd_w, stby_w, reset_w, dcs_off_w, xfer_init_w};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_srst_self_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    srst_q |=> !srst_q && idx_q == asr_pkg::RST_CHAN_IDX && pwr_q == asr_pkg::RST_PWR_MODE)
    else $error("soft reset did not restore defaults and clear");
  a_srst_set_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_cfg && (req.wdata[2] || req.wdata[5]) |=> srst_q ##1 !srst_q)
    else $error("soft reset not taken from either nibble");
  a_cfg_fixed_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_PORT_CFG |=> rdata_q[7] == 1'h0 && rdata_q[0] == 1'h0
    && rdata_q[4:3] == 2'h3 && rdata_q[6] == rdata_q[1] && rdata_q[5] == rdata_q[2])
    else $error("port configuration fixed or mirrored bits wrong");
  a_reset_defaults: assert property (@(posedge clk_sys)
    $past(sys_rst) |-> idx_q == asr_pkg::RST_CHAN_IDX && clk_q == asr_pkg::RST_CLK_STAB
    && !lsb_q && !srst_q && rdata_q == 8'h00 && !rvalid_q)
    else $error("defaults not loaded after reset");
  a_index_default: assert property (@(posedge clk_sys)
    $past(sys_rst) |-> idx_q[7:6] == 2'b00 && idx_q[5:0] == 6'h3F)
    else $error("channel index reset value wrong");
  a_read_chan_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_LOCAL_CFG && idx_q[0] |=> rvalid_q && rdata_q == $past(loc_q[0]))
    else $error("local read did not return channel A");
  a_global_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_pwr |=> pwr_q == ($past(req.wdata) & asr_pkg::MSK_PWR_MODE))
    else $error("global write depended on channel index");
  a_pwr_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pdwn_pin && !ctl.dig_reset |-> (pin_stby ? ctl.standby : ctl.full_pd))
    else $error("power-down pin action wrong");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_PORT_CFG |=> rvalid_q ##1 !rvalid_q || $past(req.rd))
    else $error("read answer not one cycle");
  a_cfg_default: assert property (@(posedge clk_sys)
    $past(sys_rst) |-> cfg_val == asr_pkg::RST_PORT_CFG)
    else $error("port configuration default wrong after reset");
  a_lsb_either_nibble: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_cfg |=> lsb_first_q == ($past(req.wdata[asr_pkg::CFG_LSB_HI]) || $past(req.wdata[asr_pkg::CFG_LSB_LO])))
    else $error("bit order not taken from either nibble");
  a_read_all_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_LOCAL_CFG && idx_q[3:0] == 4'hF |=> rdata_q == $past(loc_q[asr_pkg::CH_A]))
    else $error("all-set local read did not return channel A");
  a_global_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_CLK_STAB |=> rdata_q == $past(clk_q))
    else $error("global read depended on channel index");
  a_chip_identifier_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && req.addr == asr_pkg::ADDR_CHIP_IDENTIFIER |=> rdata_q == CHIP_IDENTIFIER)
    else $error("identifier read wrong");
  a_xfer_output: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_xfer |=> ctl.xfer_init == $past(req.wdata[asr_pkg::XFER_INIT]))
    else $error("transfer control not following its register");
  a_mode_no_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pdwn_pin |-> ctl.full_pd == (pm == asr_pkg::PM_FULL) && ctl.standby == (pm == asr_pkg::PM_STBY))
    else $error("power mode field decoded wrong");

endmodule
`default_nettype wire

// ===== include/asr_pkg.sv
`default_nettype none
package asr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_CFG   = 16'h0000;
  localparam logic [15:0] ADDR_CHIP_IDENTIFIER    = 16'h0001;
  localparam logic [15:0] ADDR_SPEED      = 16'h0002;
  localparam logic [15:0] ADDR_CHAN_IDX   = 16'h0005;
  localparam logic [15:0] ADDR_PWR_MODE   = 16'h0008;
  localparam logic [15:0] ADDR_CLK_STAB   = 16'h0009;
  localparam logic [15:0] ADDR_LOCAL_CFG  = 16'h0014;
  localparam logic [15:0] ADDR_TRANSFER   = 16'h00FF;

  // ----------------------------------------------------------------
  // port configuration fields (mirrored nibbles)
  // ----------------------------------------------------------------
  localparam int CFG_SDO_HI  = 7;
  localparam int CFG_LSB_HI  = 6;
  localparam int CFG_SRST_HI = 5;
  localparam int CFG_AW_HI   = 4;
  localparam int CFG_AW_LO   = 3;
  localparam int CFG_SRST_LO = 2;
  localparam int CFG_LSB_LO  = 1;
  localparam int CFG_SDO_LO  = 0;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CFG  = 8'h18;
  localparam logic [7:0] RST_CHAN_IDX  = 8'h3F;
  localparam logic [7:0] RST_PWR_MODE  = 8'h00;
  localparam logic [7:0] RST_CLK_STAB  = 8'h01;
  localparam logic [7:0] RST_TRANSFER  = 8'h00;
  localparam logic [7:0] RST_LOCAL_CFG = 8'h00;

  localparam logic [7:0] MSK_CHAN_IDX  = 8'h3F;
  localparam logic [7:0] MSK_PWR_MODE  = 8'h23;
  localparam logic [7:0] MSK_CLK_STAB  = 8'h01;
  localparam logic [7:0] MSK_TRANSFER  = 8'h01;
  localparam logic [7:0] MSK_LOCAL_CFG = 8'hFF;

  // ----------------------------------------------------------------
  // channel selection and power modes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN     = 6;
  localparam int CH_A         = 0;
  localparam int PWR_PIN_STBY = 5;
  localparam int CLK_DCS_OFF  = 0;
  localparam int XFER_INIT    = 0;

  localparam logic [1:0] PM_RUN   = 2'h0;
  localparam logic [1:0] PM_FULL  = 2'h1;
  localparam logic [1:0] PM_STBY  = 2'h2;
  localparam logic [1:0] PM_RESET = 2'h3;

  // ----------------------------------------------------------------
  // register access request from the serial front end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } asr_req_t;

  typedef struct packed {
    logic full_pd;
    logic standby;
    logic dig_reset;
    logic dcs_off;
    logic xfer_init;
  } asr_ctl_t;

endpackage
`default_nettype wire

// ===== tb/asr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_master_model (
  input  wire logic              clk_sys,
  output var  asr_pkg::asr_req_t req,
  input  wire logic [7:0]        rdata_q,
  input  wire logic              rvalid_q
);
  initial req = '0;
  // ------------------------------
  // byte access, one strobe cycle
  // ------------------------------
  task automatic put(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = d;
    @(posedge clk_sys);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    int n;
    put(1'b0, a, 8'h00);
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (rvalid_q === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_q;
      end
      else
      begin
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/asr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asr_regs_tb;
  logic              clk_sys;
  logic              sys_rst;
  logic              pdwn_pin;
  asr_pkg::asr_req_t req;
  logic [7:0]        rdata_q;
  logic              rvalid_q;
  logic              lsb_first_q;
  asr_pkg::asr_ctl_t ctl;
  int                fail_count = 0;
  int                tests_run = 0;
  asr_regs #(.CHIP_IDENTIFIER(8'hC3), .SPEED_CODE(3'h5)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req(req), .pdwn_pin(pdwn_pin), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .lsb_first_q(lsb_first_q), .ctl(ctl));
  asr_master_model mst_u (.clk_sys(clk_sys), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    mst_u.rd(a, d, ok);
    if (!ok)
    begin
      chk("read answer", 8'h00, 8'h01);
      wrap_up();
    end
    else
      chk($sformatf("register %h", a), d, exp);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_defaults;
    rchk(16'h0000, 8'h18);
    rchk(16'h0001, 8'hC3);
    rchk(16'h0002, 8'h50);
    rchk(16'h0005, 8'h3F);
    rchk(16'h0008, 8'h00);
    rchk(16'h0009, 8'h01);
    rchk(16'h00FF, 8'h00);
    rchk(16'h0013, 8'h00);
    chk("dcs off", {7'h00, ctl.dcs_off}, 8'h01);
  endtask
  task automatic t_port_cfg;
    mst_u.wr(16'h0000, 8'h42);
    rchk(16'h0000, 8'h5A);
    chk("lsb first", {7'h00, lsb_first_q}, 8'h01);
    mst_u.wr(16'h0000, 8'h81);
    rchk(16'h0000, 8'h18);
    chk("lsb first", {7'h00, lsb_first_q}, 8'h00);
    mst_u.wr(16'h0000, 8'h02);
    chk("lsb first", {7'h00, lsb_first_q}, 8'h01);
    mst_u.wr(16'h0001, 8'h00);
    rchk(16'h0001, 8'hC3);
  endtask
  task automatic t_soft_reset;
    mst_u.wr(16'h0008, 8'h21);
    mst_u.wr(16'h0009, 8'h00);
    mst_u.wr(16'h0005, 8'h01);
    mst_u.wr(16'h0014, 8'h99);
    mst_u.wr(16'h00FF, 8'h01);
    chk("xfer init", {7'h00, ctl.xfer_init}, 8'h01);
    mst_u.wr(16'h0000, 8'h66);
    rchk(16'h0000, 8'h18);
    rchk(16'h0008, 8'h00);
    rchk(16'h0009, 8'h01);
    rchk(16'h0005, 8'h3F);
    rchk(16'h0014, 8'h00);
    rchk(16'h00FF, 8'h00);
    chk("lsb first", {7'h00, lsb_first_q}, 8'h00);
  endtask
  task automatic t_local;
    mst_u.wr(16'h0014, 8'hAA);
    for (int ch = 0; ch < 4; ch++)
    begin
      mst_u.wr(16'h0005, 8'h01 << ch);
      rchk(16'h0014, 8'hAA);
    end
    mst_u.wr(16'h0014, 8'h55);
    mst_u.wr(16'h0005, 8'h04);
    rchk(16'h0014, 8'hAA);
    mst_u.wr(16'h0005, 8'h01);
    mst_u.wr(16'h0014, 8'h3C);
    mst_u.wr(16'h0005, 8'h30);
    mst_u.wr(16'h0014, 8'h77);
    chk("frame clock copy", dut_u.loc_q[4], 8'h77);
    chk("data clock copy", dut_u.loc_q[5], 8'h77);
    mst_u.wr(16'h0009, 8'h00);
    mst_u.wr(16'h0005, 8'h3F);
    rchk(16'h0014, 8'h3C);
    mst_u.wr(16'h0005, 8'h08);
    rchk(16'h0014, 8'h55);
    rchk(16'h0009, 8'h00);
    chk("dcs off", {7'h00, ctl.dcs_off}, 8'h00);
  endtask
  task automatic t_power;
    for (int m = 0; m < 4; m++)
    begin
      mst_u.wr(16'h0008, 8'(m));
      chk("power mode", {5'h00, ctl.full_pd, ctl.standby, ctl.dig_reset},
          {5'h00, m == 1, m == 2, m == 3});
    end
    pdwn_pin = 1'b1;
    mst_u.wr(16'h0008, 8'h00);
    chk("pin full", {6'h00, ctl.full_pd, ctl.standby}, 8'h02);
    mst_u.wr(16'h0008, 8'h20);
    chk("pin standby", {6'h00, ctl.full_pd, ctl.standby}, 8'h01);
    pdwn_pin = 1'b0;
  endtask
  task automatic t_sys_reset;
    mst_u.wr(16'h0005, 8'h02);
    mst_u.wr(16'h0009, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rchk(16'h0005, 8'h3F);
    rchk(16'h0009, 8'h01);
    rchk(16'h0008, 8'h00);
    chk("dcs off", {7'h00, ctl.dcs_off}, 8'h01);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    pdwn_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    t_defaults();
    t_port_cfg();
    t_soft_reset();
    t_local();
    t_power();
    t_sys_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
